// File: pchp_pkg.sv
// package for the paged control host port: register map, fields, types
package pchp_pkg;
   localparam int unsigned ADDR_W = 5;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned PAR_W = 24;
   localparam logic [4:0] ADDR_GLOBAL_RESET = 5'h00;
   localparam logic [4:0] ADDR_STATUS = 5'h01;
   localparam logic [4:0] ADDR_PAGE = 5'h02;
   localparam logic [4:0] ADDR_CHECKSUM = 5'h03;
   localparam logic [4:0] ADDR_GEN_SYNC = 5'h04;
   localparam logic [4:0] ADDR_CNT_SYNC = 5'h05;
   localparam logic [4:0] ADDR_RAMP_LO = 5'h06;
   localparam logic [4:0] ADDR_RAMP_HI = 5'h07;
   localparam int unsigned PAGED_BASE_BIT = 4;
   localparam int unsigned UNUSED_BIT = 3;
   localparam logic [7:0] RST_GLOBAL = 8'h00F0;
   localparam logic [7:0] RST_ZERO = 8'h0000;
   localparam logic [7:0] ALL_ONES8 = 8'h00FF;
   localparam logic [23:0] ALL_ONES24 = 24'hFF_FFFF;
   localparam int unsigned GR_EDGE_WRITE = 3;
   localparam int unsigned ST_READY = 0;
   localparam int unsigned ST_MISSED = 1;
   localparam int unsigned ST_IOV = 2;
   localparam int unsigned ST_QOV = 3;
   localparam int unsigned ST_CHECK = 4;
   localparam logic [7:0] ST_RW_MASK = 8'h001F;
   localparam int unsigned PG_EXTRA_BIT = 0;
   localparam logic [6:0] OUTPUT_PAGE = 7'h00;
   // general sync register: bits 1:0 pick sync output source, bit 2 fires one-shot
   localparam int unsigned GS_SO_SEL_LO = 0;
   localparam int unsigned GS_ONE_SHOT = 2;
   localparam int unsigned SO_DELAY = 2;
   typedef enum logic [1:0] {
      PCHP_SO_FIRST = 2'b00,
      PCHP_SO_SECOND = 2'b01,
      PCHP_SO_TERMINAL = 2'b10,
      PCHP_SO_ONESHOT = 2'b11
   } pchp_so_src_t;
   typedef struct packed {
      logic cs_n;
      logic rd_n;
      logic wr_n;
      logic [4:0] addr;
      logic [7:0] data;
   } pchp_host_in_t;
   typedef struct packed {
      logic ready_set;
      logic missed_set;
      logic iov_set;
      logic qov_set;
      logic check_set;
   } pchp_events_t;
endpackage

// File: pchp_host_port.sv
// control host port: paged register map, tri-state data, sync output select
`timescale 1ns/1ps
module pchp_host_port (
   input wire logic core_clk,
   input wire logic srst,
   input wire pchp_pkg::pchp_host_in_t host_in,
   output logic [7:0] ctl_data_out,
   output logic ctl_data_oe_n,
   input wire logic wide_word_mode,
   input wire logic four_bit_mode,
   input wire logic [23:0] out_page_data,
   output logic [23:0] par_data_out,
   output logic par_data_oe_n,
   input wire logic sync_in_first_n,
   input wire logic sync_in_second_n,
   input wire logic sync_counter_terminal,
   input wire pchp_pkg::pchp_events_t events,
   input wire logic [7:0] checksum_value,
   output logic sync_out_n,
   output logic [7:0] global_reset_controls,
   output logic [7:0] general_sync_select,
   output logic [7:0] counter_sync_select,
   output logic [15:0] ramp_counter,
   output logic [6:0] page_number,
   output logic paged_wr,
   output logic [3:0] paged_index,
   output logic [7:0] paged_wdata,
   input wire logic [7:0] paged_rdata
);
   import pchp_pkg::*;

   // host pins are asynchronous to core_clk
   pchp_host_in_t hin_s1_r, hin_r;
   always_ff @(posedge core_clk) begin
      hin_s1_r <= host_in;
      hin_r <= hin_s1_r;
   end

   logic [7:0] gres_r, status_r, page_r, gsync_r, csync_r, ramp_lo_r, ramp_hi_r;
   logic [4:0] eff_addr;
   logic rd_act, wr_lvl, wr_prev_r, wr_fire;
   logic [7:0] wdata_hold_r;
   logic [4:0] waddr_hold_r;

   // 4-bit hosts lose A3; page bit 0 stands in for it
   always_comb begin
      eff_addr = hin_r.addr;
      if (four_bit_mode) begin
         eff_addr[UNUSED_BIT] = page_r[PG_EXTRA_BIT];
      end
   end

   assign rd_act = !hin_r.cs_n && !hin_r.rd_n && hin_r.wr_n;
   assign wr_lvl = !hin_r.cs_n && !hin_r.wr_n;

   // level mode writes once at the strobe start; edge mode writes data held at the rise
   always_ff @(posedge core_clk) begin
      if (srst) begin
         wr_prev_r <= 1'b0;
         wdata_hold_r <= RST_ZERO;
         waddr_hold_r <= 5'h00;
      end else begin
         wr_prev_r <= wr_lvl;
         if (wr_lvl) begin
            wdata_hold_r <= hin_r.data;
            waddr_hold_r <= eff_addr;
         end
      end
   end

   logic edge_mode;
   logic [7:0] wdata;
   logic [4:0] waddr;
   assign edge_mode = gres_r[GR_EDGE_WRITE];
   assign wr_fire = edge_mode ? (wr_prev_r && !wr_lvl) : (wr_lvl && !wr_prev_r);
   assign wdata = edge_mode ? wdata_hold_r : hin_r.data;
   assign waddr = edge_mode ? waddr_hold_r : eff_addr;

   logic is_paged, is_unused, wr_g;
   assign is_paged = waddr[PAGED_BASE_BIT];
   assign is_unused = !waddr[PAGED_BASE_BIT] && waddr[UNUSED_BIT];
   assign wr_g = wr_fire && !is_paged && !is_unused;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         gres_r <= RST_GLOBAL;
         page_r <= RST_ZERO;
         gsync_r <= RST_ZERO;
         csync_r <= RST_ZERO;
         ramp_lo_r <= RST_ZERO;
         ramp_hi_r <= RST_ZERO;
      end else if (wr_g) begin
         case (waddr)
            ADDR_GLOBAL_RESET: gres_r <= wdata;
            ADDR_PAGE: page_r <= wdata;
            ADDR_GEN_SYNC: gsync_r <= wdata;
            ADDR_CNT_SYNC: csync_r <= wdata;
            ADDR_RAMP_LO: ramp_lo_r <= wdata;
            ADDR_RAMP_HI: ramp_hi_r <= wdata;
            default: ;
         endcase
      end
   end

   // status: hardware set of bits 1-4 wins over a host write of zero; ready_set clears bit 0
   logic st_wr;
   logic [4:0] ev_vec;
   assign st_wr = wr_g && (waddr == ADDR_STATUS);
   assign ev_vec = {events.check_set, events.qov_set, events.iov_set, events.missed_set, 1'b0};
   always_ff @(posedge core_clk) begin
      if (srst) begin
         status_r <= RST_ZERO;
      end else begin
         status_r <= (((st_wr ? wdata : status_r) & ST_RW_MASK) | {3'b000, ev_vec})
                     & ~{7'h00, events.ready_set};
      end
   end

   // read mux
   logic [7:0] rdata;
   always_comb begin
      rdata = RST_ZERO;
      if (eff_addr[PAGED_BASE_BIT]) begin
         rdata = paged_rdata;
      end else if (!eff_addr[UNUSED_BIT]) begin
         case (eff_addr)
            ADDR_GLOBAL_RESET: rdata = gres_r;
            ADDR_STATUS: rdata = status_r;
            ADDR_PAGE: rdata = page_r;
            ADDR_CHECKSUM: rdata = checksum_value;
            ADDR_GEN_SYNC: rdata = gsync_r;
            ADDR_CNT_SYNC: rdata = csync_r;
            ADDR_RAMP_LO: rdata = ramp_lo_r;
            ADDR_RAMP_HI: rdata = ramp_hi_r;
            default: rdata = RST_ZERO;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         ctl_data_out <= RST_ZERO;
         par_data_out <= ALL_ONES24;
      end else begin
         ctl_data_out <= rdata;
         par_data_out <= (page_r[7:1] == OUTPUT_PAGE) ? out_page_data : ALL_ONES24;
      end
   end
   assign ctl_data_oe_n = !rd_act;
   assign par_data_oe_n = !(rd_act && wide_word_mode);

   assign global_reset_controls = gres_r;
   assign general_sync_select = gsync_r;
   assign counter_sync_select = csync_r;
   assign ramp_counter = {ramp_hi_r, ramp_lo_r};
   assign page_number = page_r[7:1];
   assign paged_wr = wr_fire && is_paged;
   assign paged_index = waddr[3:0];
   assign paged_wdata = wdata;

   // sync inputs: two stages then a short delay line
   logic [1:0] sa_sync_r, sb_sync_r;
   logic [SO_DELAY-1:0] sa_dly_r, sb_dly_r;
   always_ff @(posedge core_clk) begin
      if (srst) begin
         sa_sync_r <= 2'b11;
         sb_sync_r <= 2'b11;
         sa_dly_r <= '1;
         sb_dly_r <= '1;
      end else begin
         sa_sync_r <= {sa_sync_r[0], sync_in_first_n};
         sb_sync_r <= {sb_sync_r[0], sync_in_second_n};
         sa_dly_r <= {sa_dly_r[SO_DELAY-2:0], sa_sync_r[1]};
         sb_dly_r <= {sb_dly_r[SO_DELAY-2:0], sb_sync_r[1]};
      end
   end

   // one-shot: one pulse per rising write of the control bit
   logic os_prev_r, os_pulse;
   always_ff @(posedge core_clk) begin
      if (srst) begin
         os_prev_r <= 1'b0;
      end else begin
         os_prev_r <= gsync_r[GS_ONE_SHOT];
      end
   end
   assign os_pulse = gsync_r[GS_ONE_SHOT] && !os_prev_r;

   pchp_so_src_t so_src;
   assign so_src = pchp_so_src_t'(gsync_r[GS_SO_SEL_LO +: 2]);
   always_ff @(posedge core_clk) begin
      if (srst) begin
         sync_out_n <= 1'b1;
      end else begin
         case (so_src)
            PCHP_SO_FIRST: sync_out_n <= sa_dly_r[SO_DELAY-1];
            PCHP_SO_SECOND: sync_out_n <= sb_dly_r[SO_DELAY-1];
            PCHP_SO_TERMINAL: sync_out_n <= !sync_counter_terminal;
            PCHP_SO_ONESHOT: sync_out_n <= !os_pulse;
            default: sync_out_n <= 1'b1;
         endcase
      end
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);

   property p_drive_only_on_read;
      ctl_data_oe_n == !(!hin_r.cs_n && !hin_r.rd_n && hin_r.wr_n);
   endproperty
   a_drive_only_on_read: assert property (p_drive_only_on_read) else $error("data bus drive mismatch");

   property p_wide_off;
      !wide_word_mode |-> par_data_oe_n;
   endproperty
   a_wide_off: assert property (p_wide_off) else $error("parallel pins driven outside wide mode");

   property p_other_page_ones;
      (page_r[7:1] != OUTPUT_PAGE) |=> par_data_out == ALL_ONES24;
   endproperty
   a_other_page_ones: assert property (p_other_page_ones) else $error("parallel pins not all ones");

   property p_no_cs_no_write;
      (hin_r.cs_n && !edge_mode) |-> !wr_fire;
   endproperty
   a_no_cs_no_write: assert property (p_no_cs_no_write) else $error("write without select");

   property p_page_write;
      (wr_g && waddr == ADDR_PAGE) |=> page_r == $past(wdata);
   endproperty
   a_page_write: assert property (p_page_write) else $error("page write lost");

   property p_unused_read_zero;
      (!eff_addr[PAGED_BASE_BIT] && eff_addr[UNUSED_BIT]) |=> ctl_data_out == RST_ZERO;
   endproperty
   a_unused_read_zero: assert property (p_unused_read_zero) else $error("unused address read nonzero");

   property p_status_set_wins;
      events.iov_set |=> status_r[ST_IOV];
   endproperty
   a_status_set_wins: assert property (p_status_set_wins) else $error("overflow flag lost");

   property p_global_read;
      (eff_addr == ADDR_RAMP_HI) |=> ctl_data_out == $past(ramp_hi_r);
   endproperty
   a_global_read: assert property (p_global_read) else $error("global read wrong");

   property p_cnt_sync_write;
      (wr_g && waddr == ADDR_CNT_SYNC) |=> counter_sync_select == $past(wdata);
   endproperty
   a_cnt_sync_write: assert property (p_cnt_sync_write) else $error("counter sync write lost");

   property p_ramp_low_write;
      (wr_g && waddr == ADDR_RAMP_LO) |=> ramp_counter[7:0] == $past(wdata);
   endproperty
   a_ramp_low_write: assert property (p_ramp_low_write) else $error("ramp low byte write lost");

   property p_unused_write_ignored;
      (wr_fire && is_unused) |=> $stable(gres_r) && $stable(page_r) && $stable(gsync_r) && $stable(csync_r);
   endproperty
   a_unused_write_ignored: assert property (p_unused_write_ignored) else $error("unused write changed a register");

   property p_terminal_out;
      (so_src == PCHP_SO_TERMINAL) && sync_counter_terminal |=> !sync_out_n;
   endproperty
   a_terminal_out: assert property (p_terminal_out) else $error("terminal count not on sync out");

   property p_one_shot_out;
      (so_src == PCHP_SO_ONESHOT) && $rose(gsync_r[GS_ONE_SHOT]) |=> !sync_out_n;
   endproperty
   a_one_shot_out: assert property (p_one_shot_out) else $error("one-shot not on sync out");

   property p_output_page_data;
      (page_r[7:1] == OUTPUT_PAGE) |=> par_data_out == $past(out_page_data);
   endproperty
   a_output_page_data: assert property (p_output_page_data) else $error("output page data missing");

   property p_wide_follows_bus;
      wide_word_mode |-> par_data_oe_n == ctl_data_oe_n;
   endproperty
   a_wide_follows_bus: assert property (p_wide_follows_bus) else $error("parallel enable differs from bus");

   sequence s_first_low;
      (so_src == PCHP_SO_FIRST) && !sa_sync_r[1];
   endsequence
   property p_sync_delay;
      s_first_low ##1 (so_src == PCHP_SO_FIRST) [*2] |=> !sync_out_n;
   endproperty
   a_sync_delay: assert property (p_sync_delay) else $error("sync out not delayed copy");
endmodule // pchp_host_port

// File: pchp_host_model.sv
// host bus model: drives strobes, address and data toward the control port
`timescale 1ns/1ps
module pchp_host_model (
   input wire logic core_clk,
   output pchp_pkg::pchp_host_in_t host_in
);
   import pchp_pkg::*;
   initial host_in = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 5'h00, data: 8'h00};
   // held 5 edges: two synchroniser flops plus the register stage must all see it
   task automatic start(input logic cs_n, input logic rd_n, input logic [4:0] a, input logic [7:0] d);
      @(posedge core_clk);
      host_in <= '{cs_n: cs_n, rd_n: rd_n, wr_n: ~rd_n, addr: a, data: d};
      repeat (5) @(posedge core_clk);
      #1;
   endtask
   // released data shows the inverse of its last value, never a stale copy
   task automatic finish();
      @(posedge core_clk);
      host_in <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: host_in.addr, data: ~host_in.data};
      repeat (4) @(posedge core_clk);
   endtask
endmodule // pchp_host_model

// File: paged_control_host_port_tb_top.sv
// self-checking bench for the paged control host port
`timescale 1ns/1ps
module paged_control_host_port_tb_top;
   import pchp_pkg::*;
   logic core_clk = 1'b0, srst = 1'b1, wide = 1'b0, four = 1'b0, s1_n = 1'b1, s2_n = 1'b1, term = 1'b0;
   logic ctl_data_oe_n, par_data_oe_n, sync_out_n, paged_wr;
   logic [7:0] ctl_data_out, global_reset_controls, general_sync_select, counter_sync_select, paged_wdata;
   logic [7:0] chk_v = 8'h00, prd = 8'h00, pg = 8'h00, d, last_pd;
   logic [23:0] opd = 24'h00_0000, par_data_out;
   logic [15:0] ramp_counter;
   logic [6:0] page_number;
   logic [3:0] paged_index, last_idx;
   logic [7:0] g [8];
   pchp_host_in_t host_in;
   pchp_events_t ev = '0;
   int n_fail = 0, n_compared = 0, n_so = 0, n_pw = 0;
   always #50 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      if (!sync_out_n) n_so++;
      if (paged_wr) begin
         n_pw++;
         last_idx = paged_index;
         last_pd = paged_wdata;
      end
   end
   pchp_host_model host_u (.core_clk(core_clk), .host_in(host_in));
   pchp_host_port dut_u (.core_clk(core_clk), .srst(srst), .host_in(host_in), .ctl_data_out(ctl_data_out),
      .ctl_data_oe_n(ctl_data_oe_n), .wide_word_mode(wide), .four_bit_mode(four), .out_page_data(opd),
      .par_data_out(par_data_out), .par_data_oe_n(par_data_oe_n), .sync_in_first_n(s1_n),
      .sync_in_second_n(s2_n), .sync_counter_terminal(term), .events(ev), .checksum_value(chk_v),
      .sync_out_n(sync_out_n), .global_reset_controls(global_reset_controls),
      .general_sync_select(general_sync_select), .counter_sync_select(counter_sync_select),
      .ramp_counter(ramp_counter), .page_number(page_number), .paged_wr(paged_wr),
      .paged_index(paged_index), .paged_wdata(paged_wdata), .paged_rdata(prd));
   task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic [7:0] rd_exp(input int a, input logic [7:0] v);
      return (a == 1) ? (v & ST_RW_MASK) : v;
   endfunction
   task automatic wr(input logic [4:0] a, input logic [7:0] v);
      host_u.start(1'b0, 1'b1, a, v);
      host_u.finish();
   endtask
   task automatic rd(input logic [4:0] a, input logic [7:0] e);
      host_u.start(1'b0, 1'b0, a, 8'h00);
      chk("read data", 24'(ctl_data_out), 24'(e));
      chk("bus enable", 24'(ctl_data_oe_n), 24'h0);
      chk("par enable", 24'(par_data_oe_n), 24'(!wide));
      if (wide) chk("par data", par_data_out, (pg[7:1] == OUTPUT_PAGE) ? opd : ALL_ONES24);
      host_u.finish();
      chk("bus released", 24'(ctl_data_oe_n), 24'h1);
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #1_000_000;
      n_fail++;
      close_out();
   end
   initial begin
      void'($urandom(98631));
      repeat (2) @(posedge core_clk);
      srst <= 1'b0;
      opd <= 24'($urandom);
      chk_v <= 8'($urandom);
      prd <= 8'($urandom);
      rd(ADDR_GLOBAL_RESET, RST_GLOBAL);
      rd(ADDR_PAGE, RST_ZERO);
      for (int p = 0; p < 2; p++) begin
         wide <= 1'(p);
         foreach (g[a]) if (a != 3) begin
            g[a] = 8'($urandom);
            if (a == 0) g[a][GR_EDGE_WRITE] = 1'b0;
            if (a == 2) pg = g[a];
            wr(5'(a), g[a]);
         end
         foreach (g[a]) if (a != 3) rd(5'(a), rd_exp(a, g[a]));
         chk("ramp", 24'(ramp_counter), 24'({g[7], g[6]}));
         chk("page", 24'(page_number), 24'(pg[7:1]));
         chk("regs", {global_reset_controls, general_sync_select, counter_sync_select}, {g[0], g[4], g[5]});
      end
      wr(ADDR_CHECKSUM, 8'($urandom));
      rd(ADDR_CHECKSUM, chk_v);
      for (int a = 8; a < 16; a++) begin
         wr(5'(a), 8'($urandom));
         rd(5'(a), 8'h00);
      end
      wr(ADDR_GLOBAL_RESET, 8'(1 << GR_EDGE_WRITE));
      d = g[5] ^ 8'hA5;
      host_u.start(1'b0, 1'b1, ADDR_CNT_SYNC, d);
      chk("edge write held", 24'(counter_sync_select), 24'(g[5]));
      host_u.finish();
      chk("edge write landed", 24'(counter_sync_select), 24'(d));
      g[5] = d;
      wr(ADDR_GLOBAL_RESET, RST_ZERO);
      rd(ADDR_GLOBAL_RESET, RST_ZERO);
      wr(ADDR_STATUS, 8'(1 << ST_READY));
      ev <= '1;
      @(posedge core_clk);
      ev <= '0;
      rd(ADDR_STATUS, 8'((1 << ST_MISSED) | (1 << ST_IOV) | (1 << ST_QOV) | (1 << ST_CHECK)));
      wr(ADDR_STATUS, RST_ZERO);
      rd(ADDR_STATUS, RST_ZERO);
      host_u.start(1'b1, 1'b1, ADDR_PAGE, ~pg);
      host_u.finish();
      host_u.start(1'b1, 1'b0, ADDR_PAGE, 8'h00);
      chk("no select enable", 24'(ctl_data_oe_n), 24'h1);
      host_u.finish();
      rd(ADDR_PAGE, pg);
      pg = 8'h00;
      wr(ADDR_PAGE, pg);
      for (int i = 0; i < 16; i++) begin
         d = 8'($urandom);
         wr(5'(16 + i), d);
         chk("paged write", {n_pw[7:0], 8'(last_idx), last_pd}, {8'(i + 1), 8'(i), d});
         rd(5'(16 + i), prd);
      end
      four <= 1'b1;
      foreach (g[k]) if (k < 2) begin
         pg = 8'(2 + k);
         wr(ADDR_PAGE, pg);
         wr(5'h10 | 5'((k ^ 1) << 3), 8'h5A);
         chk("four bit index", 24'(last_idx), 24'({k[0], 3'b000}));
      end
      four <= 1'b0;
      for (int s = 0; s < 4; s++) begin
         wr(ADDR_GEN_SYNC, 8'(s));
         repeat (8) @(posedge core_clk);
         n_so = 0;
         if (s == 3) wr(ADDR_GEN_SYNC, 8'(s + 4));
         else begin
            s1_n <= (s != 0);
            s2_n <= (s != 1);
            term <= (s == 2);
            @(posedge core_clk);
            s1_n <= 1'b1;
            s2_n <= 1'b1;
            term <= 1'b0;
         end
         repeat (12) @(posedge core_clk);
         chk("sync out pulses", 24'(n_so), 24'h1);
      end
      close_out();
   end
endmodule // paged_control_host_port_tb_top
